// ### hw/pmseq_pkg.sv
package pmseq_pkg;

   // Register byte addresses on the bus, one aligned word each.
   localparam logic [7:0] PMSEQ_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PMSEQ_STAT_ADDR = 8'h04;

   // Field positions in the mode control register.
   localparam int PMSEQ_PSM_BIT = 0;
   localparam int PMSEQ_IDLE_BIT = 1;
   localparam int PMSEQ_HALT_BIT = 2;
   localparam int PMSEQ_WAIT_BIT = 3;
   localparam int PMSEQ_DMC_BIT = 4;
   localparam int PMSEQ_DHC_BIT = 5;
   localparam int PMSEQ_REG_W = 8;
   localparam logic [5:0] PMSEQ_CTRL_RESET = 6'h00;

   // Field positions in the clock stability status register.
   localparam int PMSEQ_OLC_BIT = 0;
   localparam int PMSEQ_OMC_BIT = 1;
   localparam int PMSEQ_OHC_BIT = 2;

   // Default prescaler ratio that makes the slow tick from the main clock.
   localparam int PMSEQ_PRESCALE = 366;

   // Power modes of the sequencer, one-hot.
   typedef enum logic [5:0] {
      PMSEQ_ACTIVE = 6'h01,
      PMSEQ_TO_SAVE = 6'h02,
      PMSEQ_SAVE = 6'h04,
      PMSEQ_IDLE = 6'h08,
      PMSEQ_HALT = 6'h10,
      PMSEQ_WAKE = 6'h20
   } pmseq_state_type;

   // Control bits held in the mode control register.
   typedef struct packed {
      logic pll_disable_in_low_power;
      logic main_clock_disable_in_low_power;
      logic wait_gated_transition;
      logic halt_request;
      logic idle_request;
      logic power_save_request;
   } pmseq_ctrl_type;

   // Clock enables driven out to the oscillators and clock tree.
   typedef struct packed {
      logic main_osc_enable;
      logic pll_enable;
      logic sys_clock_enable;
      logic sys_clock_from_slow;
      logic slow_from_prescaler;
   } pmseq_clk_type;

endpackage : pmseq_pkg

// ### hw/pmseq_top.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module pmseq_top
   import pmseq_pkg::*;
#(
   parameter int PRESCALE = PMSEQ_PRESCALE
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic slow_osc_stable,
   input wire logic main_osc_stable,
   input wire logic pll_locked,
   input wire logic pll_power_down,
   input wire logic slow_crystal_input,
   input wire logic cpu_wait,
   input wire logic nmi,
   input wire logic wake_input_unit,
   input wire logic int_ack,
   output logic slow_tick,
   output logic wake_pending,
   output pmseq_clk_type clk_ctrl,
   output pmseq_state_type mode
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for inputs arriving from other clock domains or pins.
   logic [6:0] sync1_reg;
   logic [6:0] sync2_reg;
   logic olc_s;
   logic omc_s;
   logic plk_s;
   logic xtal_s;
   logic wait_s;
   logic nmi_s;
   logic wui_s;

   // Two flops before any logic looks at an asynchronous input.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
      end else begin
         sync1_reg <= {wake_input_unit, nmi, cpu_wait, slow_crystal_input,
                       pll_locked, main_osc_stable, slow_osc_stable};
         sync2_reg <= sync1_reg;
      end
   end

   assign olc_s = sync2_reg[0];
   assign omc_s = sync2_reg[1];
   assign plk_s = sync2_reg[2];
   assign xtal_s = sync2_reg[3];
   assign wait_s = sync2_reg[4];
   assign nmi_s = sync2_reg[5];
   assign wui_s = sync2_reg[6];

   ////////////////////////////////////////////////////////////////////////
   // Crystal strap and clock status.
   logic no_xtal_reg;
   logic pll_en_w;
   logic [2:0] status_w;
   logic olc_ok;
   logic omc_ok;
   logic ohc_ok;

   // The crystal input is sampled on every clock after reset release; low means absent.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         no_xtal_reg <= 1'b0;
      end else begin
         no_xtal_reg <= !xtal_s;
      end
   end

   // Without a crystal the slow clock comes from main, so it follows main.
   assign olc_ok = no_xtal_reg ? omc_s : olc_s;
   assign omc_ok = omc_s;
   // A disabled PLL counts as stable.
   assign ohc_ok = plk_s || !pll_en_w;
   assign status_w = {ohc_ok, omc_ok, olc_ok};

   ////////////////////////////////////////////////////////////////////////
   // Prescaler for the slow tick.
   localparam int PW = $clog2(PRESCALE);
   logic [PW-1:0] pre_reg;
   logic [PW-1:0] pre_next;
   logic pre_wrap;

   // Divider counts only while the prescaled path is selected.
   assign pre_wrap = (pre_reg == PW'(PRESCALE - 1));
   assign pre_next = pre_wrap ? '0 : pre_reg + PW'(1);

   // The tick pulses once per prescale period.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_reg <= '0;
         slow_tick <= 1'b0;
      end else begin
         pre_reg <= no_xtal_reg ? pre_next : '0;
         slow_tick <= no_xtal_reg && pre_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: one wait-free data phase.
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] rd_addr_w;
   logic ap_valid;
   logic wr_ctrl;
   logic [31:0] rdata_w;
   pmseq_ctrl_type ctrl_reg;
   pmseq_ctrl_type ctrl_next;
   pmseq_ctrl_type wdata_w;

   assign ap_valid = hsel && htrans[1] && hready;
   assign rd_addr_w = haddr[7:0];
   assign wr_ctrl = wr_pend_reg && (wr_addr_reg == PMSEQ_CTRL_ADDR);
   assign wdata_w = pmseq_ctrl_type'(hwdata[5:0]);

   // Read data selects control or status; other addresses read zero.
   assign rdata_w = (rd_addr_w == PMSEQ_CTRL_ADDR) ? {26'h0, ctrl_reg} :
                    (rd_addr_w == PMSEQ_STAT_ADDR) ? {29'h0, status_w} :
                    32'h0;

   // The address phase is latched; reads are answered in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_reg <= ap_valid && hwrite;
         wr_addr_reg <= haddr[7:0];
         if (ap_valid && !hwrite) begin
            hrdata <= rdata_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode sequencer.
   pmseq_state_type st_reg;
   pmseq_state_type st_next;
   logic wake_w;
   logic wait_edge;
   logic wait_d_reg;
   logic wake_lat_reg;
   logic enter_lp;
   logic go_save_now;
   logic all_disable;
   logic exit_req_reg;
   assign wait_edge = wait_s && !wait_d_reg;
   // A wake event is any NMI or enabled channel, or one still latched.
   assign wake_w = nmi_s || wui_s || wake_lat_reg;
   assign all_disable = ctrl_reg.wait_gated_transition &&
                        ctrl_reg.main_clock_disable_in_low_power &&
                        ctrl_reg.pll_disable_in_low_power;
   // Low power is entered only with a stable slow clock.
   assign enter_lp = olc_ok;
   assign go_save_now = wr_ctrl && wdata_w.power_save_request &&
                        !ctrl_reg.power_save_request &&
                        !wdata_w.wait_gated_transition;

   // Next mode; blocked transitions simply stay until status allows.
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         PMSEQ_ACTIVE: begin
            if (go_save_now) begin
               st_next = PMSEQ_TO_SAVE;
            end else if (wait_edge && ctrl_reg.wait_gated_transition &&
                         enter_lp) begin
               if (ctrl_reg.halt_request && all_disable) begin
                  st_next = PMSEQ_HALT;
               end else if (ctrl_reg.idle_request && all_disable) begin
                  st_next = PMSEQ_IDLE;
               end else if (ctrl_reg.power_save_request) begin
                  st_next = PMSEQ_SAVE;
               end
            end
         end
         PMSEQ_TO_SAVE: begin
            if (enter_lp) begin
               st_next = PMSEQ_SAVE;
            end
         end
         PMSEQ_SAVE, PMSEQ_IDLE, PMSEQ_HALT: begin
            if (wake_w) begin
               st_next = PMSEQ_WAKE;
            end else if (st_reg == PMSEQ_SAVE && exit_req_reg &&
                         omc_ok && ohc_ok) begin
               st_next = PMSEQ_ACTIVE;
            end
         end
         PMSEQ_WAKE: begin
            // Active only when main and PLL both report stable.
            if (omc_ok && ohc_ok && !ctrl_reg.pll_disable_in_low_power) begin
               st_next = PMSEQ_ACTIVE;
            end
         end
      endcase
   end

   // Control register next value: writes, hardware sets and clears.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = wdata_w;
         // Immediate power-save bit reads 1 only once Save is reached.
         if (!wdata_w.wait_gated_transition &&
             !ctrl_reg.power_save_request) begin
            ctrl_next.power_save_request = 1'b0;
         end
         // A cleared request keeps reading 1 until Active or Wake is reached.
         if (ctrl_reg.power_save_request && st_reg != PMSEQ_ACTIVE) begin
            ctrl_next.power_save_request = 1'b1;
         end
      end
      if (st_reg == PMSEQ_TO_SAVE && st_next == PMSEQ_SAVE) begin
         ctrl_next.power_save_request = 1'b1;
      end
      if (st_reg == PMSEQ_SAVE && st_next == PMSEQ_ACTIVE) begin
         ctrl_next.power_save_request = 1'b0;
      end
      if (st_next == PMSEQ_WAKE && st_reg != PMSEQ_WAKE) begin
         ctrl_next.main_clock_disable_in_low_power = 1'b0;
         ctrl_next.idle_request = 1'b0;
         ctrl_next.power_save_request = 1'b0;
      end
      // PLL disable clears only once the main oscillator is stable.
      if (st_reg == PMSEQ_WAKE && omc_ok) begin
         ctrl_next.pll_disable_in_low_power = 1'b0;
      end
      // Halt bit clears after the oscillator has stabilised.
      if (st_reg == PMSEQ_WAKE && omc_ok && ctrl_reg.halt_request) begin
         ctrl_next.halt_request = 1'b0;
      end
   end

   // State, control and wake latch registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= PMSEQ_ACTIVE;
         ctrl_reg <= pmseq_ctrl_type'(PMSEQ_CTRL_RESET);
         wait_d_reg <= 1'b0;
         wake_lat_reg <= 1'b0;
         exit_req_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ctrl_reg <= ctrl_next;
         wait_d_reg <= wait_s;
         exit_req_reg <= (st_reg == PMSEQ_SAVE) &&
            (wr_ctrl ? !wdata_w.power_save_request : exit_req_reg);
         // Set wins over acknowledge in the same cycle.
         if (nmi_s || wui_s) begin
            wake_lat_reg <= 1'b1;
         end else if (int_ack) begin
            wake_lat_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock enables derived from the mode.
   logic main_en_w;
   logic lp_w;

   assign lp_w = (st_reg == PMSEQ_SAVE) || (st_reg == PMSEQ_IDLE);
   // Main on in Active and Wake, off in Halt; disable only after entry.
   assign main_en_w = (st_reg == PMSEQ_HALT) ? 1'b0 :
                      (lp_w && ctrl_reg.main_clock_disable_in_low_power &&
                       !(no_xtal_reg && st_reg == PMSEQ_SAVE)) ? 1'b0 :
                      1'b1;
   assign pll_en_w = !pll_power_down && (st_reg != PMSEQ_HALT) &&
                     !((lp_w || st_reg == PMSEQ_WAKE) &&
                       ctrl_reg.pll_disable_in_low_power);
   // Outputs are registered; system clock stops in Idle and Halt first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
         mode <= PMSEQ_ACTIVE;
         wake_pending <= 1'b0;
      end else begin
         clk_ctrl.main_osc_enable <= main_en_w;
         clk_ctrl.pll_enable <= pll_en_w;
         clk_ctrl.sys_clock_enable <= (st_next != PMSEQ_IDLE) &&
                                      (st_next != PMSEQ_HALT);
         clk_ctrl.sys_clock_from_slow <= (st_reg == PMSEQ_SAVE) ||
                                         (st_reg == PMSEQ_TO_SAVE);
         clk_ctrl.slow_from_prescaler <= no_xtal_reg;
         mode <= st_reg;
         // Wake only restores clocks; the handler sees this pending flag.
         wake_pending <= wake_lat_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   property p_status_zero;
      @(posedge hclk) disable iff (!hresetn)
      (ap_valid && !hwrite && rd_addr_w == PMSEQ_STAT_ADDR) |=>
         hrdata[7:3] == 5'h00;
   endproperty
   a_status_zero: assert property (p_status_zero)
      else $error("status upper bits not zero");
   property p_no_lp_unstable;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg == PMSEQ_ACTIVE && !olc_ok) |=> st_reg != PMSEQ_IDLE &&
         st_reg != PMSEQ_HALT && st_reg != PMSEQ_SAVE;
   endproperty
   a_no_lp_unstable: assert property (p_no_lp_unstable)
      else $error("low power entered without slow clock");
   property p_active_needs_main;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg != PMSEQ_ACTIVE && st_next == PMSEQ_ACTIVE) |-> omc_ok && ohc_ok;
   endproperty
   a_active_needs_main: assert property (p_active_needs_main)
      else $error("active entered with unstable clock");
   property p_halt_main_off;
      @(posedge hclk) disable iff (!hresetn)
      st_reg == PMSEQ_HALT |=> !clk_ctrl.main_osc_enable;
   endproperty
   a_halt_main_off: assert property (p_halt_main_off)
      else $error("main oscillator on in halt");

   property p_active_main_on;
      @(posedge hclk) disable iff (!hresetn)
      st_reg == PMSEQ_ACTIVE |=> clk_ctrl.main_osc_enable;
   endproperty
   a_active_main_on: assert property (p_active_main_on)
      else $error("main oscillator off in active");

   property p_wake_leaves;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg == PMSEQ_IDLE && wake_w) |=> st_reg == PMSEQ_WAKE;
   endproperty
   a_wake_leaves: assert property (p_wake_leaves)
      else $error("wake did not leave idle");

   property p_wake_clears;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg == PMSEQ_WAKE) |-> !ctrl_reg.main_clock_disable_in_low_power
         && !ctrl_reg.idle_request;
   endproperty
   a_wake_clears: assert property (p_wake_clears)
      else $error("disable bit still set during wake");

   property p_wake_latch;
      @(posedge hclk) disable iff (!hresetn)
      (wake_lat_reg && !int_ack) |=> wake_lat_reg;
   endproperty
   a_wake_latch: assert property (p_wake_latch)
      else $error("wake latch lost");

   c_halt: cover property (@(posedge hclk) st_reg == PMSEQ_HALT);
   c_save: cover property (@(posedge hclk) st_reg == PMSEQ_SAVE);
   c_wake: cover property (@(posedge hclk)
      st_reg == PMSEQ_WAKE ##1 st_reg == PMSEQ_ACTIVE);

endmodule : pmseq_top

// ### dv/pmseq_partner.sv
`timescale 1ns/1ns
// Behavioural oscillators and PLL that answer the sequencer's enables.
module pmseq_partner
   import pmseq_pkg::*;
#(
   parameter int MAIN_START = 6,
   parameter int PLL_START = 5,
   parameter int SLOW_START = 40
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire pmseq_clk_type clk_ctrl,
   input wire logic pll_power_down,
   input wire logic slow_crystal_input,
   output logic slow_osc_stable,
   output logic main_osc_stable,
   output logic pll_locked
);
   int main_cnt = 0;
   int pll_cnt = 0;
   int slow_cnt = 0;

   ////////////////////////////////////////////////////////////////////////
   // The crystal starts after power-up; with the pin tied low it never runs.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_cnt <= 0;
      end else if (slow_crystal_input && slow_cnt < SLOW_START) begin
         slow_cnt <= slow_cnt + 1;
      end
   end

   // Each source settles after its start-up count and drops when stopped.
   always @(posedge hclk) begin
      if (!clk_ctrl.main_osc_enable) begin
         main_cnt <= 0;
      end else if (main_cnt < MAIN_START) begin
         main_cnt <= main_cnt + 1;
      end
      if (!clk_ctrl.pll_enable || pll_power_down || !main_osc_stable) begin
         pll_cnt <= 0;
      end else if (pll_cnt < PLL_START) begin
         pll_cnt <= pll_cnt + 1;
      end
   end

   // Stability levels as the monitors would report them.
   assign slow_osc_stable = slow_crystal_input && slow_cnt == SLOW_START;
   assign main_osc_stable = main_cnt == MAIN_START;
   assign pll_locked = pll_cnt == PLL_START;
endmodule : pmseq_partner

// ### dv/tb.sv
`timescale 1ns/1ns
module tb
   import pmseq_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, cpu_wait, nmi, wake_in, int_ack;
   logic pd, xtal, hreadyout, hresp, slow_st, main_st, pll_lk;
   logic slow_tick, wake_pending, pll_q;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   pmseq_clk_type clk_ctrl;
   pmseq_state_type mode, prev_mode;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   int ticks;

   pmseq_top #(.PRESCALE(4)) i_pmseq_top (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .slow_osc_stable(slow_st), .main_osc_stable(main_st),
      .pll_locked(pll_lk), .pll_power_down(pd), .slow_crystal_input(xtal),
      .cpu_wait(cpu_wait), .nmi(nmi), .wake_input_unit(wake_in),
      .int_ack(int_ack), .slow_tick(slow_tick),
      .wake_pending(wake_pending), .clk_ctrl(clk_ctrl), .mode(mode));

   pmseq_partner #(.PLL_START(2)) i_pmseq_partner (.hclk(hclk),
      .hresetn(hresetn), .clk_ctrl(clk_ctrl), .pll_power_down(pd),
      .slow_crystal_input(xtal), .slow_osc_stable(slow_st),
      .main_osc_stable(main_st), .pll_locked(pll_lk));

   ////////////////////////////////////////////////////////////////////////
   // Clock at 100 MHz.
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask : idle

   // One AHB-Lite single word transfer, held until hready is seen high.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, a, wd, d);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h00000000, d);
      chk(nm, d, exp);
      chk("response", {31'h0, hresp}, 32'h0);
   endtask : rd

   // Software waits on a status bit before its next step.
   task automatic poll(input int b);
      int n;
      logic [31:0] d;
      n = 0;
      d = 32'h00000000;
      while (d[b] !== 1'b1 && n < 100) begin
         bus(1'b0, PMSEQ_STAT_ADDR, 32'h00000000, d);
         n++;
      end
      chk("status poll", {31'h0, d[b]}, 32'h00000001);
   endtask : poll

   task automatic wait_mode(input pmseq_state_type t);
      int n;
      n = 0;
      while (mode !== t && n < 300) begin
         @(posedge hclk);
         n++;
      end
      chk("mode", {26'h0, mode}, {26'h0, t});
   endtask : wait_mode

   // WAIT executed, a wake event, an acknowledge and a reset.
   task automatic do_wait;
      cpu_wait <= 1'b1;
      idle(3);
      cpu_wait <= 1'b0;
      idle(1);
   endtask : do_wait

   task automatic wake(input logic use_nmi);
      nmi <= use_nmi;
      wake_in <= ~use_nmi;
      idle(3);
      nmi <= 1'b0;
      wake_in <= 1'b0;
      idle(1);
   endtask : wake

   task automatic ack;
      int_ack <= 1'b1;
      idle(1);
      int_ack <= 1'b0;
      idle(2);
   endtask : ack

   task automatic rst;
      hresetn <= 1'b0;
      idle(8);
      hresetn <= 1'b1;
      idle(3);
   endtask : rst

   ////////////////////////////////////////////////////////////////////////
   // Mode entries are checked against the live clock levels.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (hresetn === 1'b1 && mode !== prev_mode) begin
         if (mode === PMSEQ_ACTIVE) begin
            chk("main at active", {31'h0, main_st}, 1);
            chk("pll at active", {31'h0, pll_lk | pd}, 1);
         end
         if (mode === PMSEQ_SAVE || mode === PMSEQ_IDLE
             || mode === PMSEQ_HALT) begin
            chk("slow at entry", {31'h0, slow_st | ~xtal}, 1);
         end
      end
      if (hresetn === 1'b1 && mode === PMSEQ_ACTIVE) begin
         chk("main on", {31'h0, clk_ctrl.main_osc_enable}, 1);
      end
      if (hresetn === 1'b1 && clk_ctrl.pll_enable === 1'b1 && !pll_q) begin
         chk("pll after main", {31'h0, main_st}, 1);
      end
      pll_q <= clk_ctrl.pll_enable;
      prev_mode <= mode;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence of register accesses and pin events.
   initial begin
      {hresetn, hsel, hwrite, cpu_wait, nmi, wake_in, int_ack, pd} = 8'h00;
      {haddr, hwdata, htrans, hsize, xtal, pll_q} = {66'h0, 3'b010, 2'b10};
      prev_mode = PMSEQ_ACTIVE;
      rst;
      rd("status at reset", PMSEQ_STAT_ADDR, 32'h6);
      rd("ctrl at reset", PMSEQ_CTRL_ADDR, 32'h0);
      rd("unmapped", 8'h08, 32'h0);
      wr(PMSEQ_STAT_ADDR, 32'hffffffff);
      pd <= 1'b1;
      idle(6);
      rd("pll off status", PMSEQ_STAT_ADDR, 32'h6);
      pd <= 1'b0;
      idle(8);
      wr(PMSEQ_CTRL_ADDR, 32'h01);
      idle(10);
      chk("held back", {26'h0, mode}, {26'h0, PMSEQ_TO_SAVE});
      rd("psm pending", PMSEQ_CTRL_ADDR, 32'h0);
      poll(PMSEQ_OLC_BIT);
      wr(PMSEQ_CTRL_ADDR, 32'h01);
      wait_mode(PMSEQ_SAVE);
      chk("cpu on slow", clk_ctrl.sys_clock_from_slow, 1);
      rd("psm set", PMSEQ_CTRL_ADDR, 32'h01);
      wr(PMSEQ_CTRL_ADDR, 32'h11);
      idle(6);
      chk("main off", clk_ctrl.main_osc_enable, 0);
      wr(PMSEQ_CTRL_ADDR, 32'h01);
      poll(PMSEQ_OMC_BIT);
      wr(PMSEQ_CTRL_ADDR, 32'h00);
      wait_mode(PMSEQ_ACTIVE);
      rd("psm clear", PMSEQ_CTRL_ADDR, 32'h0);
      wr(PMSEQ_CTRL_ADDR, 32'h39);
      rd("gated psm", PMSEQ_CTRL_ADDR, 32'h39);
      idle(10);
      chk("before wait", {26'h0, mode}, {26'h0, PMSEQ_ACTIVE});
      do_wait;
      wait_mode(PMSEQ_SAVE);
      idle(6);
      chk("main off in save", clk_ctrl.main_osc_enable, 0);
      wake(1'b1);
      wait_mode(PMSEQ_ACTIVE);
      rd("ctrl after wake", PMSEQ_CTRL_ADDR, 32'h08);
      idle(5);
      chk("wake latched", wake_pending, 1);
      ack;
      chk("wake cleared", wake_pending, 0);
      wr(PMSEQ_CTRL_ADDR, 32'h3a);
      do_wait;
      wait_mode(PMSEQ_IDLE);
      idle(4);
      chk("idle clocks", clk_ctrl[4:2], 0);
      wake(1'b0);
      wait_mode(PMSEQ_ACTIVE);
      rd("idle cleared", PMSEQ_CTRL_ADDR, 32'h08);
      ack;
      wr(PMSEQ_CTRL_ADDR, 32'h3c);
      do_wait;
      wait_mode(PMSEQ_HALT);
      idle(4);
      chk("halt clocks", clk_ctrl[4:2], 0);
      wake(1'b1);
      wait_mode(PMSEQ_ACTIVE);
      rd("halt cleared", PMSEQ_CTRL_ADDR, 32'h08);
      ack;
      xtal <= 1'b0;
      rst;
      chk("prescaled slow", clk_ctrl.slow_from_prescaler, 1);
      ticks = 0;
      repeat (40) begin
         @(posedge hclk);
         if (slow_tick === 1'b1) ticks++;
      end
      chk("tick count", ticks, 10);
      rd("status no xtal", PMSEQ_STAT_ADDR, 32'h7);
      wr(PMSEQ_CTRL_ADDR, 32'h11);
      wait_mode(PMSEQ_SAVE);
      idle(6);
      chk("main kept", clk_ctrl.main_osc_enable, 1);
      wr(PMSEQ_CTRL_ADDR, 32'h01);
      wr(PMSEQ_CTRL_ADDR, 32'h00);
      wait_mode(PMSEQ_ACTIVE);
      wr(PMSEQ_CTRL_ADDR, 32'h3c);
      do_wait;
      wait_mode(PMSEQ_HALT);
      wake(1'b0);
      wait_mode(PMSEQ_ACTIVE);
      chk("slow from main", clk_ctrl.slow_from_prescaler, 1);
      end_of_test;
   end
endmodule : tb
